// *** bfs_pkg.sv ***
/*
 * Shared constants, carrier types and state codes of the buck fault supervisor.
 * Assumes a 50 MHz pclk and comparator results already synchronous to it.
 */
package bfs_pkg;
   // ************************************************************
   // Timebase.
   // ************************************************************
   localparam int CLK_MHZ = 50;
   localparam int TICK_CYCLES = CLK_MHZ;
   localparam int TICK_W = 6;
   localparam real UV_DEGLITCH_MS = 0.25;
   localparam int OV_DEGLITCH_US = 256;
   localparam int PG_GOOD_US = 64;
   localparam int PG_BAD_US = 32;
   localparam int MODE_SAMPLE_US = 64;
   localparam int SOFTSTART_MS = 2;
   localparam int HICCUP_MS = 25;
   localparam int DG_W = 9;
   localparam int TMR_W = 15;
   localparam logic [DG_W-1:0] UV_DG_TICKS = DG_W'(int'(UV_DEGLITCH_MS * 1000.0));
   localparam logic [DG_W-1:0] OV_DG_TICKS = DG_W'(OV_DEGLITCH_US);
   localparam logic [DG_W-1:0] PGG_DG_TICKS = DG_W'(PG_GOOD_US);
   localparam logic [DG_W-1:0] PGB_DG_TICKS = DG_W'(PG_BAD_US);
   localparam logic [TMR_W-1:0] MODE_TICKS = TMR_W'(MODE_SAMPLE_US);
   localparam int SOFTSTART_TICKS = SOFTSTART_MS * 1000;
   localparam int HICCUP_TICKS = HICCUP_MS * 1000;
   localparam int DG_UV = 0;
   localparam int DG_OV = 1;
   localparam int DG_PGG = 2;
   localparam int DG_PGB = 3;
   localparam int DG_N = 4;
   // ************************************************************
   // Register map.
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
   localparam logic [ADDR_W-1:0] EVENT_OFS = 12'h008;
   localparam int CTRL_STANDBY_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam int EV_CL = 0;
   localparam int EV_UV = 1;
   localparam int EV_OV = 2;
   localparam int EV_OT = 3;
   localparam int EV_N = 4;
   localparam logic [EV_N-1:0] EV_RST = 4'h0;
   localparam int ST_MODE_BIT = 8;
   localparam int ST_PG_BIT = 9;
   localparam int ST_OVF_BIT = 10;
   localparam int ST_FIX_BIT = 11;
   localparam int ST_ULL_BIT = 12;
   localparam int ST_SKIP_BIT = 13;
   // ************************************************************
   // Types.
   // ************************************************************
   typedef enum logic [7:0] {
      BFS_OFF = 8'h01,
      BFS_MODE = 8'h02,
      BFS_SS = 8'h04,
      BFS_RUN = 8'h08,
      BFS_UVH = 8'h10,
      BFS_OVD = 8'h20,
      BFS_OVH = 8'h40,
      BFS_OT = 8'h80
   } bfs_state_t;
   typedef struct packed {
      logic enable;
      logic reg_ok;
      logic supply_present;
      logic ls_over_limit;
      logic set_request;
      logic fb_below_uv;
      logic fb_above_ov;
      logic fb_in_window;
      logic fb_out_window;
      logic temp_over_trip;
      logic temp_released;
      logic zero_cross;
      logic light_load;
      logic mode_strap_low;
   } bfs_sense_t;
   typedef struct packed {
      logic hs_set;
      logic ls_on;
      logic fixed_on_time;
      logic discharge_on;
      logic good_flag_o;
      logic good_flag_oe;
      logic standby;
      logic continuous_conduction;
      logic pulse_skip;
      logic ultra_light_load_state;
   } bfs_drive_t;
endpackage

// *** bfs_properties.sv ***
/* Port checker of bfs_top.
   Assumes it is bound to bfs_top and sees its clock, reset and power stage ports only. */
module bfs_properties
   import bfs_pkg::*;
#(
   parameter int SS_TICKS = SOFTSTART_TICKS
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Power stage.
   input wire bfs_sense_t sense,
   input wire bfs_drive_t drive_q,
   input wire logic [TMR_W-1:0] ref_ramp_q
);
   // ************************************************************
   // Properties.
   // ************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_hot;
      sense.temp_over_trip && ref_ramp_q != '0 ##1 sense.temp_over_trip;
   endsequence
   sequence s_off;
      (!sense.enable && sense.supply_present) [*2];
   endsequence
   chk_limit_no_set: assert property (sense.ls_over_limit |=> !drive_q.hs_set)
      else $error("high side set during limit");
   chk_limit_fixed_on: assert property (sense.ls_over_limit && ref_ramp_q != '0 |=> drive_q.fixed_on_time)
      else $error("no fixed on-time after limit");
   chk_lockout_off: assert property (!sense.reg_ok [*2] |=> !drive_q.hs_set && ref_ramp_q == '0)
      else $error("switching in lockout");
   chk_thermal_off: assert property (s_hot |=> !drive_q.hs_set && !drive_q.ls_on && drive_q.discharge_on)
      else $error("thermal trip not obeyed");
   chk_enable_discharge: assert property (s_off |=> drive_q.discharge_on)
      else $error("no discharge when disabled");
   chk_enable_flag_low: assert property (s_off |=> drive_q.good_flag_oe)
      else $error("good flag released when disabled");
   chk_supply_gone_hiz: assert property (!sense.supply_present |=> !drive_q.good_flag_oe)
      else $error("good flag driven without supply");
   chk_standby_stop: assert property (s_off |=> drive_q.standby && !drive_q.hs_set)
      else $error("switching in standby");
   chk_ramp_steps: assert property (ref_ramp_q != $past(ref_ramp_q) |-> ref_ramp_q == '0 || (ref_ramp_q == $past(ref_ramp_q) + 15'h1 && ref_ramp_q <= SS_TICKS))
      else $error("reference ramp stepped");
endmodule

// *** bfs_stage.sv ***
/* Behavioural power stage, divider and supply model.
   Assumes the bench sets the analog conditions in cond. */
module bfs_stage
   import bfs_pkg::*;
(
   // Clock.
   input wire logic pclk,
   // Analog conditions.
   input wire bfs_sense_t cond,
   // Supervisor outputs.
   input wire bfs_drive_t drive_q,
   output bfs_sense_t sense
);
   // ************************************************************
   // Comparators.
   // ************************************************************
   logic [6:0] phase_q = 7'h0;
   always_ff @(posedge pclk) begin
      phase_q <= (phase_q == 7'h63) ? 7'h0 : phase_q + 7'h1;
   end
   always_comb begin
      sense = cond;
      sense.set_request = (phase_q == 7'h0);
      sense.ls_over_limit = cond.ls_over_limit && drive_q.ls_on;
   end
endmodule

// *** bfs_top.sv ***
/*
 * Fault and status supervisor of a synchronous step-down converter with an APB
 * register slave. Assumes comparator inputs synchronous to pclk and an external
 * pull-up on the output good flag pin.
 */
// Design decisions made here: the APB interface to the registers and the address map.
// Overview of operation
// R1 - Low-side current above limit keeps low side on and blocks high-side set.
// R2 - After a current-limit event, fixed on-time is used while limiting continues; here it stays on until switching stops.
// R3 - Feedback under 65% for 0.25 ms shuts down, restart after 25 ms.
// R4 - Feedback over 125% for 256 us flags overvoltage and discharges.
// R5 - After overvoltage clears, discharge stays on 25 ms, then soft start.
// R6 - Internal supply under lockout holds shutdown; recovery needs no latch.
// R7 - Temperature over 165 C turns both switches off and discharges.
// R8 - Thermal shutdown ends after 30 C hysteresis, then restarts by soft start.
// R9 - Discharge on for undervoltage, overvoltage, overtemperature and enable-low off.
// R10 - Good flag released after feedback in 90 to 110% for 64 us.
// R11 - Good flag driven low after feedback out of 85 to 115% for 32 us.
// R12 - Good flag low in thermal shutdown, enable-low and lockout.
// R13 - Good flag reads high impedance when input supply is below 2 V.
// R14 - Enable low requests standby; switching stops and standby holds.
// R15 - Enabled and above lockout, switch normally; continuous when current stays positive.
// R16 - Forced-continuous selection keeps continuous conduction at light load.
// R17 - Pulse-skip selection skips pulses once ripple valley reaches zero.
// R18 - Pulse-skip at very light load enters ultra-light-load state.
// R19 - Selection sampled 64 us after lockout release, held until restart.
// R20 - Selection pin low means pulse-skip, open means forced-continuous.
// R21 - Every start ramps the reference over 2 ms soft start.
// R22 - Deglitch timers restart from zero when their condition drops early.
// R23 - All intervals count from one timebase, counters sized for the longest.
module bfs_top
   import bfs_pkg::*;
#(
   parameter int SS_TICKS = SOFTSTART_TICKS,
   parameter int HIC_TICKS = HICCUP_TICKS
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Power stage.
   input wire bfs_sense_t sense,
   output bfs_drive_t drive_q,
   output logic [TMR_W-1:0] ref_ramp_q
);
   bfs_state_t st_q;
   bfs_state_t st_d;
   logic [TICK_W-1:0] tick_cnt_q;
   logic tick_q;
   logic [TMR_W-1:0] tmr_q;
   logic [DG_W-1:0] dg_cnt_q [DG_N];
   logic [DG_N-1:0] dg_in;
   logic [DG_N-1:0] dg_done;
   logic [31:0] ctrl_q;
   logic [EV_N-1:0] ev_q;
   logic [EV_N-1:0] ev_set;
   logic mode_forced_continuous_mode_q;
   logic pg_rel_q;
   logic fixed_q;
   logic limit_q;
   logic en_eff;
   logic switching;
   logic wr_go;
   logic [31:0] rd_val;
   logic rd_err;
   logic [31:0] status;

   assign en_eff = sense.enable & ~ctrl_q[CTRL_STANDBY_BIT];
   assign switching = (st_q == BFS_SS) || (st_q == BFS_RUN);

   // ************************************************************
   // Timebase of one microsecond ticks.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin // [R23]
         tick_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // ************************************************************
   // Deglitch timers.
   // ************************************************************
   assign dg_in[DG_UV] = sense.fb_below_uv && (st_q == BFS_RUN);
   assign dg_in[DG_OV] = sense.fb_above_ov && switching;
   assign dg_in[DG_PGG] = sense.fb_in_window && switching;
   assign dg_in[DG_PGB] = sense.fb_out_window;

   localparam logic [DG_W-1:0] DG_LIM [DG_N] = '{UV_DG_TICKS, OV_DG_TICKS,
                                                 PGG_DG_TICKS, PGB_DG_TICKS};

   generate
      for (genvar i = 0; i < DG_N; i++) begin : g_dg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dg_cnt_q[i] <= '0;
            end else if (!dg_in[i]) begin // [R22]
               dg_cnt_q[i] <= '0;
            end else if (tick_q && dg_cnt_q[i] != DG_LIM[i]) begin // [R23]
               dg_cnt_q[i] <= dg_cnt_q[i] + 1'b1;
            end
         end
         assign dg_done[i] = dg_in[i] && (dg_cnt_q[i] == DG_LIM[i]);
      end
   endgenerate

   // ************************************************************
   // Operating state.
   // ************************************************************
   always_comb begin
      st_d = st_q;
      if (!sense.reg_ok || !en_eff) begin // [R6] [R14]
         st_d = BFS_OFF;
      end else if (sense.temp_over_trip && st_q != BFS_OT && st_q != BFS_OFF) begin // [R7]
         st_d = BFS_OT;
      end else begin
         case (st_q)
            BFS_OFF: st_d = BFS_MODE;
            BFS_MODE: begin
               if (tmr_q >= MODE_TICKS) begin // [R19]
                  st_d = BFS_SS;
               end
            end
            BFS_SS: begin
               if (dg_done[DG_OV]) begin
                  st_d = BFS_OVD;
               end else if (tmr_q >= TMR_W'(SS_TICKS)) begin // [R21]
                  st_d = BFS_RUN;
               end
            end
            BFS_RUN: begin
               if (dg_done[DG_OV]) begin // [R4]
                  st_d = BFS_OVD;
               end else if (dg_done[DG_UV]) begin // [R3]
                  st_d = BFS_UVH;
               end
            end
            BFS_UVH: begin
               if (tmr_q >= TMR_W'(HIC_TICKS)) begin // [R3]
                  st_d = BFS_SS;
               end
            end
            BFS_OVD: begin
               if (!sense.fb_above_ov) begin // [R5]
                  st_d = BFS_OVH;
               end
            end
            BFS_OVH: begin
               if (tmr_q >= TMR_W'(HIC_TICKS)) begin // [R5]
                  st_d = BFS_SS;
               end
            end
            BFS_OT: begin
               if (sense.temp_released) begin // [R8]
                  st_d = BFS_SS;
               end
            end
            default: st_d = BFS_OFF;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= BFS_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_q <= '0;
      end else if (st_d != st_q) begin
         tmr_q <= '0;
      end else if (tick_q && tmr_q != '1) begin // [R23]
         tmr_q <= tmr_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_forced_continuous_mode_q <= 1'b0;
      end else if (st_q == BFS_MODE && st_d == BFS_SS) begin // [R19]
         mode_forced_continuous_mode_q <= ~sense.mode_strap_low; // [R20]
      end
   end

   // ************************************************************
   // Current limit and output good flag.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fixed_q <= 1'b0;
         limit_q <= 1'b0;
      end else begin
         limit_q <= switching & sense.ls_over_limit;
         if (!switching) begin
            fixed_q <= 1'b0;
         end else if (sense.ls_over_limit) begin // [R2]
            fixed_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_rel_q <= 1'b0;
      end else if (st_d == BFS_OFF || st_d == BFS_OT) begin // [R12]
         pg_rel_q <= 1'b0;
      end else if (dg_done[DG_PGB]) begin // [R11]
         pg_rel_q <= 1'b0;
      end else if (dg_done[DG_PGG]) begin // [R10]
         pg_rel_q <= 1'b1;
      end
   end

   // ************************************************************
   // Power stage drive.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_q <= '0;
         ref_ramp_q <= '0;
      end else begin
         drive_q.hs_set <= switching & sense.set_request & ~sense.ls_over_limit; // [R1]
         drive_q.ls_on <= switching & (sense.ls_over_limit | mode_forced_continuous_mode_q |
                                       ~sense.zero_cross); // [R1] [R17]
         drive_q.fixed_on_time <= fixed_q | (switching & sense.ls_over_limit); // [R2]
         drive_q.discharge_on <= (st_q == BFS_UVH) || (st_q == BFS_OVD) ||
                                 (st_q == BFS_OVH) || (st_q == BFS_OT) ||
                                 (st_q == BFS_OFF && !en_eff); // [R9] [R7] [R5] [R4]
         drive_q.good_flag_o <= 1'b0;
         drive_q.good_flag_oe <= sense.supply_present & ~pg_rel_q; // [R13] [R12]
         drive_q.standby <= (st_q == BFS_OFF) && !en_eff; // [R14]
         drive_q.continuous_conduction <= switching & (mode_forced_continuous_mode_q |
                                                      ~sense.zero_cross); // [R15] [R16]
         drive_q.pulse_skip <= switching & ~mode_forced_continuous_mode_q & sense.zero_cross; // [R17]
         drive_q.ultra_light_load_state <= (st_q == BFS_RUN) && !mode_forced_continuous_mode_q &&
                                           sense.light_load; // [R18]
         if (st_q == BFS_SS) begin // [R21]
            ref_ramp_q <= tmr_q;
         end else if (st_q == BFS_RUN) begin
            ref_ramp_q <= TMR_W'(SS_TICKS);
         end else begin
            ref_ramp_q <= '0;
         end
      end
   end

   // ************************************************************
   // Event flags.
   // ************************************************************
   assign ev_set[EV_CL] = switching & sense.ls_over_limit & ~limit_q;
   assign ev_set[EV_UV] = (st_d == BFS_UVH) && (st_q != BFS_UVH);
   assign ev_set[EV_OV] = (st_d == BFS_OVD) && (st_q != BFS_OVD);
   assign ev_set[EV_OT] = (st_d == BFS_OT) && (st_q != BFS_OT);

   assign wr_go = psel & penable & pready & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_q <= EV_RST;
      end else if (wr_go && paddr == EVENT_OFS) begin
         ev_q <= (ev_q & ~pwdata[EV_N-1:0]) | ev_set;
      end else begin
         ev_q <= ev_q | ev_set;
      end
   end

   // ************************************************************
   // APB slave.
   // ************************************************************
   always_comb begin
      status = '0;
      status[7:0] = st_q;
      status[ST_MODE_BIT] = mode_forced_continuous_mode_q;
      status[ST_PG_BIT] = pg_rel_q;
      status[ST_OVF_BIT] = (st_q == BFS_OVD);
      status[ST_FIX_BIT] = fixed_q;
      status[ST_ULL_BIT] = drive_q.ultra_light_load_state;
      status[ST_SKIP_BIT] = drive_q.pulse_skip;
      rd_err = 1'b0;
      case (paddr)
         CTRL_OFS: rd_val = ctrl_q;
         STATUS_OFS: rd_val = status;
         EVENT_OFS: rd_val = {{(32 - EV_N){1'b0}}, ev_q};
         default: begin
            rd_val = '0;
            rd_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_go && paddr == CTRL_OFS) begin
         ctrl_q <= {31'h00000000, pwdata[CTRL_STANDBY_BIT]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : rd_val;
         pslverr <= rd_err;
      end else begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
   end
endmodule

// *** tb.sv ***
/* Self-checking bench of bfs_top with the power stage model.
   Assumes bfs_pkg, bfs_stage and bfs_properties are compiled first. */
module tb
   import bfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Signals and instances.
   // ************************************************************
   localparam int SS = 20;
   localparam int HIC = 40;
   localparam int TK = 50;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   bfs_sense_t cond = '0;
   bfs_sense_t sense;
   bfs_drive_t drive_q;
   logic [TMR_W-1:0] ref_ramp_q;
   logic [31:0] rd_q;
   logic rd_err;
   int miscompares = 0;
   int checks_done = 0;
   int seed = 32'h0172;
   bfs_top #(.SS_TICKS(SS), .HIC_TICKS(HIC)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
      .drive_q(drive_q), .ref_ramp_q(ref_ramp_q));
   bfs_stage stage (.pclk(pclk), .cond(cond), .drive_q(drive_q), .sense(sense));
   always #10 pclk = ~pclk;
   // ************************************************************
   // Tasks.
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h wanted %h", $time, seen, want);
      end
   endtask
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic run(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         give_verdict();
      end
      rd_q = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic st(input logic [7:0] code);
      apb(1'b0, STATUS_OFS, '0);
      check(32'(rd_q[7:0]), 32'(code));
   endtask
   task automatic wait_st(input logic [7:0] code, input int lim);
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_OFS, '0);
         n++;
      end while (rd_q[7:0] !== code && n < lim);
      check(32'(rd_q[7:0]), 32'(code));
      if (rd_q[7:0] !== code) begin
         give_verdict();
      end
   endtask
   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      run(2);
      presetn <= 1'b1;
      cond.supply_present <= 1'b1;
      cond.fb_in_window <= 1'b1;
      apb(1'b0, CTRL_OFS, '0);
      check(rd_q, CTRL_RST);
      st(8'(BFS_OFF));
      apb(1'b0, 12'hffc, '0);
      check({rd_q[30:0], rd_err}, 32'h1);
      for (int m = 0; m < 2; m++) begin
         cond.mode_strap_low <= (m == 0);
         cond.enable <= 1'b1;
         cond.reg_ok <= 1'b1;
         wait_st(8'(BFS_RUN), 1500);
         check(32'(rd_q[ST_MODE_BIT]), 32'(m));
         check(32'(ref_ramp_q), 32'(SS));
         cond.zero_cross <= 1'b1;
         cond.light_load <= 1'b1;
         cond.mode_strap_low <= (m != 0);
         run(100);
         check(32'({drive_q.pulse_skip, drive_q.ultra_light_load_state}), m ? 0 : 3);
         check(32'({drive_q.continuous_conduction, drive_q.ls_on}), m ? 3 : 0);
         st(8'(BFS_RUN));
         check(32'(rd_q[ST_MODE_BIT]), 32'(m));
         cond.zero_cross <= 1'b0;
         cond.light_load <= 1'b0;
         cond.enable <= 1'b0;
         run(5);
         check(32'({drive_q.standby, drive_q.discharge_on, drive_q.good_flag_oe}), 7);
         cond.supply_present <= 1'b0;
         run(3);
         check(32'(drive_q.good_flag_oe), 0);
         cond.supply_present <= 1'b1;
         st(8'(BFS_OFF));
      end
      cond.enable <= 1'b1;
      wait_st(8'(BFS_RUN), 1500);
      run(70 * TK);
      check(32'(drive_q.good_flag_oe), 0);
      cond.fb_in_window <= 1'b0;
      cond.fb_out_window <= 1'b1;
      run(25 * TK);
      check(32'(drive_q.good_flag_oe), 0);
      run(12 * TK);
      check(32'(drive_q.good_flag_oe), 1);
      cond.fb_out_window <= 1'b0;
      cond.fb_in_window <= 1'b1;
      cond.ls_over_limit <= 1'b1;
      run(200);
      check(32'({drive_q.hs_set, drive_q.ls_on, drive_q.fixed_on_time}), 3);
      cond.ls_over_limit <= 1'b0;
      run(200);
      check(32'(drive_q.fixed_on_time), 1);
      apb(1'b1, EVENT_OFS, 32'h1);
      cond.fb_below_uv <= 1'b1;
      run(240 * TK);
      cond.fb_below_uv <= 1'b0;
      run(TK + ($random(seed) & 31));
      cond.fb_below_uv <= 1'b1;
      run(240 * TK);
      st(8'(BFS_RUN));
      wait_st(8'(BFS_UVH), 300);
      check(32'(drive_q.discharge_on), 1);
      cond.fb_below_uv <= 1'b0;
      run(35 * TK);
      st(8'(BFS_UVH));
      wait_st(8'(BFS_SS), 100);
      wait_st(8'(BFS_RUN), 300);
      cond.fb_above_ov <= 1'b1;
      run(250 * TK);
      st(8'(BFS_RUN));
      wait_st(8'(BFS_OVD), 200);
      check(32'({rd_q[ST_OVF_BIT], drive_q.discharge_on}), 3);
      cond.fb_above_ov <= 1'b0;
      wait_st(8'(BFS_OVH), 20);
      run(35 * TK);
      st(8'(BFS_OVH));
      check(32'(drive_q.discharge_on), 1);
      wait_st(8'(BFS_SS), 100);
      run(2 * TK);
      cond.temp_over_trip <= 1'b1;
      run(5);
      st(8'(BFS_OT));
      check(32'({drive_q.hs_set, drive_q.ls_on, drive_q.discharge_on, drive_q.good_flag_oe}), 3);
      cond.temp_over_trip <= 1'b0;
      run(TK);
      st(8'(BFS_OT));
      cond.temp_released <= 1'b1;
      wait_st(8'(BFS_SS), 20);
      cond.temp_released <= 1'b0;
      apb(1'b0, EVENT_OFS, '0);
      check(32'(rd_q[3:0]), 32'he);
      apb(1'b1, EVENT_OFS, 32'hf);
      apb(1'b0, EVENT_OFS, '0);
      check(rd_q, 0);
      cond.reg_ok <= 1'b0;
      run(5);
      st(8'(BFS_OFF));
      check(32'({drive_q.good_flag_o, drive_q.good_flag_oe}), 1);
      cond.reg_ok <= 1'b1;
      wait_st(8'(BFS_RUN), 1500);
      apb(1'b1, CTRL_OFS, 32'h1);
      apb(1'b0, CTRL_OFS, '0);
      check(rd_q, 32'h1);
      st(8'(BFS_OFF));
      apb(1'b1, CTRL_OFS, 32'h0);
      presetn <= 1'b0;
      run(2);
      presetn <= 1'b1;
      wait_st(8'(BFS_MODE), 20);
      give_verdict();
   end
endmodule
bind bfs_top bfs_properties #(.SS_TICKS(SS_TICKS)) chk (.pclk(pclk), .presetn(presetn),
   .sense(sense), .drive_q(drive_q), .ref_ramp_q(ref_ramp_q));
